// ---- design/cbc_pkg.sv ----
package cbc_pkg;
  localparam logic [11:0] ADDR_PERIPH  = 12'h014;
  localparam logic [11:0] ADDR_PIN     = 12'h018;
  localparam logic [11:0] ADDR_PORT    = 12'h01c;
  localparam logic [11:0] ADDR_CTRL    = 12'h030;
  localparam logic [11:0] ADDR_STATUS  = 12'h050;
  localparam logic [11:0] ADDR_MASK    = 12'h054;
  localparam logic [31:0] PERIPH_VALUE = 32'h0107_0013;
  localparam logic [31:0] PIN_VALUE    = 32'h3f0f_01c3;
  localparam logic [31:0] PORT_VALUE   = 32'h0000_001f;
  localparam int          CNT_LSB      = 2;
  localparam int          CNT_MSB      = 15;
  localparam int          CNT_W        = 14;
  localparam int          SEL_BIT      = 1;
  localparam int          WAIT_BIT     = 0;
  localparam logic [13:0] CNT_RESET    = 14'h1fff;
  localparam logic        SEL_RESET    = 1'h0;
  localparam logic        WAIT_RESET   = 1'h1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [3:0]  OSC_DIV      = 4'h1;
endpackage

// ---- design/cbc_top.sv ----
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
module cbc_top
  import cbc_pkg::*;
#(
  parameter logic [3:0] OSC_DIVIDE = OSC_DIV   // Clocks per oscillator tick.
) (
  input  wire logic        sys_clk,        // System clock, 25 MHz.
  input  wire logic        resetn,         // Asynchronous reset, low.
  input  wire logic        brownout_in,    // Detector output, high on event.
  input  wire logic [11:0] s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [11:0] s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready,   // Read data ready.
  output logic             brownout_reset, // Reset request pulse.
  output logic             irq             // Level interrupt.
);

  typedef enum logic [1:0] {CBC_IDLE, CBC_WAIT, CBC_HOLD} cbc_state_t;

  logic [CNT_W-1:0] filter_delay_count;
  logic             reset_not_interrupt_select;
  logic             wait_and_resample_enable;
  logic             status;
  logic             mask;
  logic [CNT_W:0]   delay_cnt;
  logic [3:0]       div_cnt;
  logic             osc_tick;
  logic             det_prev;
  logic             confirm;
  cbc_state_t       state;
  logic             aw_held;
  logic             w_held;
  logic [11:0]      aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             do_write;
  logic [31:0]      next_rdata;
  logic             next_rok;

  // Oscillator tick stands in for the internal oscillator on one clock.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt  <= 4'h0;
      osc_tick <= 1'b0;
    end else if (div_cnt + 4'h1 >= OSC_DIVIDE) begin
      div_cnt  <= 4'h0;
      osc_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 4'h1;
      osc_tick <= 1'b0;
    end
  end

  // Write address and data are caught separately, in either order.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Ready is offered only while the channel is empty.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
    end
  end

  // Write response; flag registers accept writes silently.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case ({aw_addr[11:2], 2'b00})
        ADDR_PERIPH, ADDR_PIN, ADDR_PORT, ADDR_CTRL,
        ADDR_STATUS, ADDR_MASK: s_axi_bresp <= RESP_OKAY;
        default:                s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; only the low two byte lanes hold fields.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      filter_delay_count         <= CNT_RESET;
      reset_not_interrupt_select <= SEL_RESET;
      wait_and_resample_enable   <= WAIT_RESET;
      mask                       <= 1'b0;
    end else if (do_write) begin
      if ({aw_addr[11:2], 2'b00} == ADDR_CTRL) begin
        if (w_strb[0]) begin
          filter_delay_count[5:0]    <= w_data[7:CNT_LSB];
          reset_not_interrupt_select <= w_data[SEL_BIT];
          wait_and_resample_enable   <= w_data[WAIT_BIT];
        end
        if (w_strb[1]) begin
          filter_delay_count[13:6] <= w_data[CNT_MSB:8];
        end
      end
      if ({aw_addr[11:2], 2'b00} == ADDR_MASK && w_strb[0]) begin
        mask <= w_data[0];
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rok   = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      ADDR_PERIPH: next_rdata = PERIPH_VALUE;
      ADDR_PIN:    next_rdata = PIN_VALUE;
      ADDR_PORT:   next_rdata = PORT_VALUE;
      ADDR_CTRL:   next_rdata = {16'h0000, filter_delay_count,
                                 reset_not_interrupt_select,
                                 wait_and_resample_enable};
      ADDR_STATUS: next_rdata = {31'h0, status};
      ADDR_MASK:   next_rdata = {31'h0, mask};
      default:     next_rok   = 1'b0;
    endcase
  end

  // Reserved bits read zero, which is one permitted value.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Filter state machine; the counter is one bit wider than the field.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= CBC_IDLE;
      delay_cnt <= '0;
      det_prev  <= 1'b0;
      confirm   <= 1'b0;
    end else begin
      det_prev <= brownout_in;
      confirm  <= 1'b0;
      case (state)
        CBC_IDLE: begin
          if (brownout_in && !det_prev) begin
            if (wait_and_resample_enable) begin
              delay_cnt <= '0;
              state     <= CBC_WAIT;
            end else begin
              confirm <= 1'b1;
            end
          end
        end
        CBC_WAIT: begin
          if (delay_cnt >= {1'b0, filter_delay_count}) begin
            if (brownout_in) begin
              confirm <= 1'b1;
            end
            state <= CBC_HOLD;
          end else if (osc_tick) begin
            delay_cnt <= delay_cnt + 1'b1;
          end
        end
        CBC_HOLD: begin
          state <= CBC_IDLE;
        end
        default: state <= CBC_IDLE;
      endcase
    end
  end

  // Response: reset pulse or sticky status; the set wins over a clear.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status         <= 1'b0;
      brownout_reset <= 1'b0;
      irq            <= 1'b0;
    end else begin
      brownout_reset <= confirm && reset_not_interrupt_select;
      if (confirm && !reset_not_interrupt_select) begin
        status <= 1'b1;
      end else if (do_write && {aw_addr[11:2], 2'b00} == ADDR_STATUS
                   && w_strb[0] && w_data[0]) begin
        status <= 1'b0;
      end
      irq <= status && mask;
    end
  end

endmodule

// ---- dv/cbc_chk.sv ----
`timescale 1ns/10ps
module cbc_chk (
  input wire logic        sys_clk,        // Clock.
  input wire logic        resetn,         // Reset, low.
  input wire logic        brownout_in,    // Detector.
  input wire logic [11:0] s_axi_araddr,   // Read address.
  input wire logic        s_axi_arvalid,  // Address valid.
  input wire logic        s_axi_arready,  // Address ready.
  input wire logic [31:0] s_axi_rdata,    // Read data.
  input wire logic [1:0]  s_axi_rresp,    // Read response.
  input wire logic        s_axi_rvalid,   // Data valid.
  input wire logic        s_axi_rready,   // Data ready.
  input wire logic        brownout_reset  // Reset pulse.
);
  // All checks use the system clock and rest while reset is low.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A read address taken at one offset.
  sequence s_ar(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  a_periph_flags: assert property (s_ar(12'h014) |=>
    s_axi_rdata == 32'h0107_0013) else $error("bad peripheral flags");
  a_pin_flags: assert property (s_ar(12'h018) |=>
    s_axi_rdata == 32'h3f0f_01c3) else $error("bad pin flags");
  a_port_flags: assert property (s_ar(12'h01c) |=>
    s_axi_rdata == 32'h0000_001f) else $error("bad port flags");
  a_unmapped_err: assert property (s_ar(12'h0f0) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad refusal");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("late read data");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read data held too long");
  a_reset_pulse: assert property ($rose(brownout_reset) |=>
    $fell(brownout_reset)) else $error("reset pulse too long");
  a_reset_cause: assert property (brownout_reset |->
    $past(brownout_in, 2) || $past(brownout_in, 3)) else $error("bad reset");
endmodule
bind cbc_top cbc_chk u_chk (.*);

// ---- dv/cbc_bod_model.sv ----
`timescale 1ns/10ps
module cbc_bod_model (
  input wire logic        sys_clk,     // Clock.
  input wire logic        go,          // Start a dip.
  input wire logic [15:0] len,         // Dip length.
  output logic            brownout_in  // Detector level.
);
  logic [15:0] left = 16'h0;
  // The level stays high for len cycles; low is its only released level.
  always_ff @(posedge sys_clk)
    left <= go ? len : left - {15'h0, left != 16'h0};
  assign brownout_in = left != 16'h0;
endmodule

// ---- dv/cbc_top_test.sv ----
`timescale 1ns/10ps
module cbc_top_test;
  logic        sys_clk = 1'b0, resetn = 1'b0, go = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, brownout_in, brownout_reset, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [11:0] fa [3] = '{12'h014, 12'h018, 12'h01c};
  logic [31:0] fv [3] = '{32'h0107_0013, 32'h3f0f_01c3, 32'h0000_001f};
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [15:0] len = 16'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_fail = 0, compares = 0, n;
  // Clock, the device and the detector beside it.
  always #20 sys_clk = ~sys_clk;
  cbc_top uut (.*);
  cbc_bod_model bod (.*);
  task automatic chk(string nm, logic [31:0] e, g);
    compares++;
    if (g !== e) n_fail++;
    if (g !== e) $display("ERROR %s expected %h seen %h", nm, e, g);
  endtask
  // One bus transfer; each channel is held until its own handshake.
  task automatic xfer(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid));
    resp = w ? s_axi_bresp : s_axi_rresp;
    rdat = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rc(logic [11:0] a, logic [31:0] e, string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic ev(logic [15:0] l, int w);
    go <= 1'b1;
    len <= l;
    @(posedge sys_clk) go <= 1'b0;
    repeat (w) @(posedge sys_clk);
  endtask
  task automatic t_flags;
    rc(12'h030, 32'h7ffd, "control");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, fa[i], 32'h0);
      chk("flag write resp", 32'h0, {30'h0, resp});
      rc(fa[i], fv[i], "flags");
    end
    rc(12'h0f0, 32'h0, "unmapped");
    chk("refusal", 32'h2, {30'h0, resp});
    xfer(1'b1, 12'h0f0, 32'h0);
    chk("write refusal", 32'h2, {30'h0, resp});
    $display("flags test done");
  endtask
  // Count of 20 with waiting on: a short dip is noise, a long one counts.
  task automatic t_event;
    xfer(1'b1, 12'h030, 32'h51);
    ev(16'h5, 60);
    rc(12'h050, 32'h0, "noise");
    ev(16'h3c, 8);
    rc(12'h050, 32'h0, "waiting");
    repeat (60) @(posedge sys_clk);
    rc(12'h050, 32'h1, "confirmed");
    chk("masked", 32'h0, {31'h0, irq});
    xfer(1'b1, 12'h054, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    xfer(1'b1, 12'h050, 32'h1);
    chk("cleared", 32'h0, {31'h0, irq});
    $display("event test done");
  endtask
  task automatic t_rst(logic [31:0] c, int lo, hi);
    xfer(1'b1, 12'h030, c);
    ev(16'h28, 0);
    for (n = 0; n < 99 && !brownout_reset; n++) @(posedge sys_clk);
    chk("delay", 32'h1, {31'h0, n >= lo && n <= hi});
    repeat (60) @(posedge sys_clk);
    rc(12'h050, 32'h0, "no status");
    $display("reset test done");
  endtask
  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence; the reset dip goes through without and with waiting.
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_flags;
    t_event;
    t_rst(32'h2, 2, 6);
    t_rst(32'h53, 20, 30);
    print_verdict;
  end
  // A hang is cut short well after the tests would have ended.
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    print_verdict;
  end
endmodule
